// file: design/stc_reference_conditioner.sv
// speed reference conditioning and speed/torque mode selection
// assumes all inputs synchronous to clk and settings held steady by software
// Function
// - three skip centres, 0 to 200.0 Hz
// - one shared skip width, up to 20.0 Hz
// - rising command held below band until past
// - falling command held above band until past
// - pot up/down ramps, both or none holds
// - pot memory off restarts at zero
// - trim step percent added or subtracted
// - trim codes 1c/1d, reopen restores analog
// - torque mode only under flux vector
// - torque reference delay filter, 0-1000 ms
// - speed limit source analog or programmed
// - programmed limit signed, sign follows run
// - bias added to speed limit as margin
// - mode change waits switchover time
// - analog inputs frozen during switchover
// - analog function 13 torque, 14 compensation
// - torque direction from reference sign
// - unipolar forward only, code 78 inverts
// - torque values are 0.1 % of rated torque
`timescale 1ns/1ps
`include "stc_defines.svh"
module stc_reference_conditioner
    import stc_pkg::*;
#(
    parameter int NDI        = 6,
    parameter int TICK_CYCLES = `STC_TICK_CYCLES
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // digital contacts and their function codes
    input  wire logic [NDI-1:0]    digitalIn,
    input  wire logic [NDI*8-1:0]  digitalInputFunction,
    // run command
    input  wire logic              runCmd,
    input  wire logic              runReverse,
    // frequency settings, 0.1 Hz units
    input  wire logic [15:0]       skipCentreFirst,
    input  wire logic [15:0]       skipCentreSecond,
    input  wire logic [15:0]       skipCentreThird,
    input  wire logic [15:0]       skipBandWidth,
    input  wire logic [15:0]       maxOutputFrequency,
    // potentiometer reference
    input  wire logic              potReferenceMemory,
    input  wire logic              potSelect,
    input  wire logic [15:0]       accelStep,
    input  wire logic [15:0]       decelStep,
    input  wire logic              potRestore,
    input  wire logic [15:0]       potRestoreValue,
    // analog reference and trim
    input  wire logic [15:0]       analogReference,
    input  wire logic [7:0]        trimStepLevel,
    // analog terminals, 0.1 % of rated torque
    input  wire stc_val_t          analogTerminalTwo,
    input  wire stc_val_t          analogTerminalThree,
    input  wire logic [7:0]        analogIn2Function,
    input  wire logic [7:0]        analogIn3Function,
    input  wire logic              analogTwoUnipolar,
    input  wire logic              analogThreeUnipolar,
    // torque control settings
    input  wire logic [3:0]        controlMethodSelect,
    input  wire logic              controlModeSelect,
    input  wire logic [15:0]       torqueRefDelay,
    input  wire logic [1:0]        speedLimitSource,
    input  wire logic signed [7:0] speedLimitValue,
    input  wire logic [7:0]        speedLimitBias,
    input  wire logic [15:0]       modeSwitchTimer,
    // conditioned outputs
    output logic [15:0]            speedRef,
    output logic [15:0]            motorPotReference,
    output logic [15:0]            potSavedRef,
    output logic                   torqueMode,
    output logic                   switchPending,
    output stc_val_t               torqueRef,
    output stc_val_t               torqueComp,
    output logic                   torqueReverse,
    output stc_val_t               speedLimitHigh,
    output stc_val_t               speedLimitLow
);
    logic [31:0]   tickCount;
    logic          msTick;
    logic          runPrev;
    logic          chgPrev;
    logic          switchedMode;
    logic [15:0]   swTimer;
    logic [15:0]   refHeld;
    stc_val_t      heldTwo;
    stc_val_t      heldThree;
    stc_sw_state_t swState;
    logic [31:0]   next_tickCount;
    logic          next_msTick;
    logic [15:0]   next_speedRef;
    logic [15:0]   next_pot;
    logic [15:0]   next_potSaved;
    logic          next_chgPrev;
    logic          next_switchedMode;
    logic [15:0]   next_swTimer;
    logic [15:0]   next_refHeld;
    stc_val_t      next_heldTwo;
    stc_val_t      next_heldThree;
    stc_sw_state_t next_swState;
    logic          next_torqueMode;
    stc_val_t      next_torqueRef;
    stc_val_t      next_torqueComp;
    stc_val_t      next_limHigh;
    stc_val_t      next_limLow;

    // any contact assigned the given function and closed
    function automatic logic fnActive(input logic [7:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NDI; i++) begin
            if (digitalIn[i] && digitalInputFunction[i*8 +: 8] == code) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : fnActive

    // one skip band; a zero centre leaves the band unused
    function automatic logic [15:0] skipBand(input logic [15:0] v,
                                             input logic [15:0] prev,
                                             input logic [15:0] c);
        logic [16:0] lo;
        logic [16:0] hi;
        lo = (c > skipBandWidth) ? {1'b0, c} - {1'b0, skipBandWidth}
                                 : 17'h00000;
        hi = {1'b0, c} + {1'b0, skipBandWidth};
        if (c == 16'h0000 || {1'b0, v} < lo || {1'b0, v} > hi) begin
            return v;
        end
        // previous output tells which side we approached from
        if (prev <= c) begin
            return lo[15:0];
        end
        return hi[15:0];
    endfunction : skipBand

    // percent of max frequency as a 0.1 Hz quantity
    function automatic logic [15:0] pctOfMax(input logic [7:0] p);
        logic [23:0] prod;
        prod = 24'(maxOutputFrequency) * 24'(p);
        return 16'(prod / `STC_PERCENT);
    endfunction : pctOfMax

    // millisecond enable
    always_comb begin
        next_msTick    = 1'b0;
        next_tickCount = tickCount + 32'h00000001;
        if (tickCount >= 32'(TICK_CYCLES - 1)) begin
            next_tickCount = 32'h00000000;
            next_msTick    = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tickCount <= 32'h00000000;
            msTick    <= 1'b0;
        end else begin
            tickCount <= next_tickCount;
            msTick    <= next_msTick;
        end
    end

    // potentiometer reference
    always_comb begin
        logic        up;
        logic        dn;
        logic [16:0] sum;
        up  = fnActive(`STC_FN_POT_UP);
        dn  = fnActive(`STC_FN_POT_DOWN);
        sum = {1'b0, motorPotReference} + {1'b0, accelStep};
        next_pot      = motorPotReference;
        next_potSaved = potSavedRef;
        if (runPrev && !runCmd) begin
            next_potSaved = motorPotReference;
        end
        if (potRestore) begin
            next_pot = potRestoreValue;
        end else if (runCmd && !runPrev) begin
            if (potReferenceMemory != `STC_MEMORY_ON) begin
                next_pot = 16'h0000;
            end
        end else if (runCmd && msTick && up && !dn) begin
            next_pot = (sum > {1'b0, maxOutputFrequency})
                     ? maxOutputFrequency : sum[15:0];
        end else if (runCmd && msTick && dn && !up) begin
            next_pot = (motorPotReference > decelStep)
                     ? motorPotReference - decelStep : 16'h0000;
        end
    end

    // trim on the analog reference, skip bands on the selected reference
    always_comb begin
        logic [15:0] ref0;
        logic [15:0] trim;
        logic [16:0] tsum;
        logic        tu;
        logic        td;
        logic [15:0] s1;
        logic [15:0] s2;
        ref0 = (swState == STC_SW_WAIT) ? refHeld : analogReference;
        trim = pctOfMax(trimStepLevel);
        tsum = {1'b0, ref0} + {1'b0, trim};
        tu   = fnActive(`STC_FN_TRIM_UP);
        td   = fnActive(`STC_FN_TRIM_DOWN);
        // open trim contacts fall straight back to ref0
        if (tu && !td) begin
            ref0 = tsum[15:0];
        end else if (td && !tu) begin
            ref0 = (ref0 > trim) ? ref0 - trim : 16'h0000;
        end
        if (potSelect) begin
            ref0 = motorPotReference;
        end
        s1 = skipBand(ref0, speedRef, skipCentreFirst);
        s2 = skipBand(s1, speedRef, skipCentreSecond);
        next_speedRef = skipBand(s2, speedRef, skipCentreThird);
    end

    // speed/torque switchover with frozen analog inputs
    always_comb begin
        logic chg;
        chg = fnActive(`STC_FN_MODE_CHANGE);
        next_chgPrev      = chg;
        next_swState      = swState;
        next_swTimer      = swTimer;
        next_switchedMode = switchedMode;
        next_refHeld      = refHeld;
        next_heldTwo      = heldTwo;
        next_heldThree    = heldThree;
        if (chg != chgPrev) begin
            next_swState = STC_SW_WAIT;
            next_swTimer = modeSwitchTimer;
            if (swState == STC_SW_IDLE) begin
                next_refHeld = analogReference;
                next_heldTwo = analogTerminalTwo;
                next_heldThree = analogTerminalThree;
            end
        end else begin
            unique case (swState)
                STC_SW_IDLE: begin
                end
                STC_SW_WAIT: begin
                    if (swTimer == 16'h0000) begin
                        next_switchedMode = chg;
                        next_swState      = STC_SW_IDLE;
                    end else if (msTick) begin
                        next_swTimer = swTimer - 16'h0001;
                    end
                end
            endcase
        end
        next_torqueMode = `STC_MODE_SPEED;
        if (controlMethodSelect == `STC_METHOD_FLUX_VEC) begin
            next_torqueMode = (controlModeSelect == `STC_MODE_TORQUE)
                            || switchedMode;
        end
    end

    // torque reference, compensation, filter and speed limits
    always_comb begin
        stc_val_t inTwo;
        stc_val_t inThree;
        stc_val_t tq;
        stc_val_t cp;
        logic signed [17:0] diff;
        logic signed [15:0] lim;
        logic signed [15:0] bias;
        lim = $signed(speedRef);
        inTwo = (swState == STC_SW_WAIT) ? heldTwo : analogTerminalTwo;
        inThree = (swState == STC_SW_WAIT) ? heldThree : analogTerminalThree;
        if (analogTwoUnipolar && inTwo < 0) begin
            inTwo = 16'sh0000;
        end
        if (analogThreeUnipolar && inThree < 0) begin
            inThree = 16'sh0000;
        end
        tq = 16'sh0000;
        cp = 16'sh0000;
        // values stay in 0.1 % of rated torque
        if (analogIn2Function == `STC_AIN_TORQUE_REF) tq = tq + inTwo;
        if (analogIn3Function == `STC_AIN_TORQUE_REF) tq = tq + inThree;
        if (analogIn2Function == `STC_AIN_TORQUE_COMP) cp = cp + inTwo;
        if (analogIn3Function == `STC_AIN_TORQUE_COMP) cp = cp + inThree;
        if (fnActive(`STC_FN_POL_REVERSE)) begin
            tq = -tq;
        end
        next_torqueComp = cp;
        // first-order lag stepped each ms; zero delay passes straight
        diff = 18'(tq) - 18'(torqueRef);
        next_torqueRef = torqueRef;
        if (torqueRefDelay == 16'h0000) begin
            next_torqueRef = tq;
        end else if (msTick) begin
            next_torqueRef = 16'(18'(torqueRef)
                + diff / $signed({2'b00, torqueRefDelay}));
        end
        if (speedLimitSource == `STC_LIMIT_PROGRAM) begin
            lim = $signed(pctOfMax(speedLimitValue < 0 ? 8'(-speedLimitValue)
                                   : speedLimitValue));
            if (speedLimitValue < 0) lim = -lim;
        end
        if (runReverse) begin
            lim = -lim;
        end
        bias = $signed(pctOfMax(speedLimitBias));
        next_limHigh = ((lim > 0) ? lim : 16'sh0000) + bias;
        next_limLow  = ((lim < 0) ? lim : 16'sh0000) - bias;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            speedRef          <= 16'h0000;
            motorPotReference <= 16'h0000;
            potSavedRef       <= 16'h0000;
            runPrev           <= 1'b0;
            chgPrev           <= 1'b0;
            switchedMode      <= 1'b0;
            swTimer           <= 16'h0000;
            swState           <= STC_SW_IDLE;
            refHeld           <= 16'h0000;
            heldTwo           <= 16'sh0000;
            heldThree         <= 16'sh0000;
            torqueMode        <= 1'b0;
            switchPending     <= 1'b0;
            torqueRef         <= 16'sh0000;
            torqueComp        <= 16'sh0000;
            torqueReverse     <= 1'b0;
            speedLimitHigh    <= 16'sh0000;
            speedLimitLow     <= 16'sh0000;
        end else begin
            speedRef          <= next_speedRef;
            motorPotReference <= next_pot;
            potSavedRef       <= next_potSaved;
            runPrev           <= runCmd;
            chgPrev           <= next_chgPrev;
            switchedMode      <= next_switchedMode;
            swTimer           <= next_swTimer;
            swState           <= next_swState;
            refHeld           <= next_refHeld;
            heldTwo           <= next_heldTwo;
            heldThree         <= next_heldThree;
            torqueMode        <= next_torqueMode;
            switchPending     <= (next_swState == STC_SW_WAIT);
            torqueRef         <= next_torqueRef;
            torqueComp        <= next_torqueComp;
            torqueReverse     <= next_torqueRef < 0;
            speedLimitHigh    <= next_limHigh;
            speedLimitLow     <= next_limLow;
        end
    end
endmodule : stc_reference_conditioner

// file: pkg/stc_defines.svh
// constants of the speed/torque reference conditioner
// assumes a 125 MHz clock and settings already range-checked by software
`ifndef STC_DEFINES_SVH
`define STC_DEFINES_SVH
`define STC_CLK_KHZ          125000
`define STC_TICK_MS          1
`define STC_TICK_CYCLES      (`STC_CLK_KHZ * `STC_TICK_MS)
`define STC_FN_POT_UP        8'h10
`define STC_FN_POT_DOWN      8'h11
`define STC_FN_TRIM_UP       8'h1c
`define STC_FN_TRIM_DOWN     8'h1d
`define STC_FN_MODE_CHANGE   8'h71
`define STC_FN_POL_REVERSE   8'h78
`define STC_AIN_TORQUE_REF   8'h0d
`define STC_AIN_TORQUE_COMP  8'h0e
`define STC_METHOD_FLUX_VEC  4'h3
`define STC_MODE_SPEED       1'h0
`define STC_MODE_TORQUE      1'h1
`define STC_LIMIT_ANALOG     2'h1
`define STC_LIMIT_PROGRAM    2'h2
`define STC_MEMORY_ON        1'h1
`define STC_SKIP_MAX         16'h07d0
`define STC_SKIP_DEF         16'h0000
`define STC_WIDTH_MAX        16'h00c8
`define STC_WIDTH_DEF        16'h000a
`define STC_TRIM_DEF         8'h0a
`define STC_TRIM_MAX         8'h64
`define STC_LIMIT_DEF        8'h00
`define STC_BIAS_DEF         8'h0a
`define STC_PCT_MAX          8'h78
`define STC_DELAY_MAX        16'h03e8
`define STC_DELAY_DEF        16'h0000
`define STC_PERCENT          24'h000064
`endif

// file: pkg/stc_pkg.sv
// types shared by the conditioner and its bench
// assumes stc_defines.svh sits beside it on the include path
package stc_pkg;
    typedef logic signed [15:0] stc_val_t;
    typedef enum logic {STC_SW_IDLE, STC_SW_WAIT} stc_sw_state_t;
endpackage : stc_pkg

// file: testbench/stc_rc_assertions.sv
// concurrent checks on the reference conditioner ports
// assumes bind into stc_reference_conditioner, single clk domain
`timescale 1ns/1ps
module stc_rc_assertions
    import stc_pkg::*;
#(
    parameter int NDI         = 6,
    parameter int TICK_CYCLES = 125000
) (
    // clock and reset
    input wire logic             clk,
    input wire logic             rst,
    // watched inputs
    input wire logic [NDI-1:0]   digitalIn,
    input wire logic [NDI*8-1:0] digitalInputFunction,
    input wire logic             runCmd,
    input wire logic             potRestore,
    input wire logic [3:0]       controlMethodSelect,
    input wire logic [15:0]      torqueRefDelay,
    input wire logic [15:0]      modeSwitchTimer,
    // watched outputs
    input wire logic [15:0]      speedRef,
    input wire logic [15:0]      motorPotReference,
    input wire logic             torqueMode,
    input wire logic             switchPending,
    input wire stc_val_t         torqueRef,
    input wire logic             torqueReverse,
    input wire stc_val_t         speedLimitHigh,
    input wire stc_val_t         speedLimitLow
);
    logic potUp, potDown, polRev;
    int   pendCnt;
    // contact decode, same function map as the design
    always_comb begin
        potUp = 1'b0;
        potDown = 1'b0;
        polRev = 1'b0;
        for (int i = 0; i < NDI; i++) begin
            potUp |= digitalIn[i] && digitalInputFunction[i*8 +: 8] == 8'h10;
            potDown |= digitalIn[i] && digitalInputFunction[i*8 +: 8] == 8'h11;
            polRev |= digitalIn[i] && digitalInputFunction[i*8 +: 8] == 8'h78;
        end
    end
    // a counter, since a switchover lasts far beyond any repetition
    always_ff @(posedge clk) begin
        if (rst || !switchPending) pendCnt <= 0;
        else pendCnt <= pendCnt + 1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_reset_quiet;
        $fell(rst) |-> speedRef == 16'h0000 && motorPotReference == 16'h0000
            && !torqueMode && !switchPending;
    endproperty
    property p_pot_hold;
        (potUp == potDown && runCmd && !potRestore)[*3]
            |-> $stable(motorPotReference);
    endproperty
    property p_pot_rise;
        (potUp && !potDown && runCmd && !potRestore)[*3]
            |-> motorPotReference >= $past(motorPotReference);
    endproperty
    property p_pot_fall;
        (potDown && !potUp && runCmd && !potRestore)[*3]
            |-> motorPotReference <= $past(motorPotReference);
    endproperty
    property p_mode_needs_vector;
        (controlMethodSelect != 4'h3)[*3] |-> !torqueMode;
    endproperty
    property p_limit_margin;
        speedLimitHigh >= 16'sh0000 && speedLimitLow <= 16'sh0000;
    endproperty
    property p_torque_sign;
        $stable(torqueRef) |-> torqueReverse == torqueRef[15];
    endproperty
    property p_frozen;
        (switchPending && torqueRefDelay == 16'h0000 && $stable(polRev))[*3]
            |-> $stable(torqueRef);
    endproperty
    property p_switch_bound;
        pendCnt <= (int'(modeSwitchTimer) + 2) * TICK_CYCLES + 4;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs not clear after reset");
    a_pot_hold: assert property (p_pot_hold)
        else $error("pot moved with both or no contact");
    a_pot_rise: assert property (p_pot_rise)
        else $error("pot fell while raising");
    a_pot_fall: assert property (p_pot_fall)
        else $error("pot rose while lowering");
    a_mode_needs_vector: assert property (p_mode_needs_vector)
        else $error("torque mode outside vector method");
    a_limit_margin: assert property (p_limit_margin)
        else $error("speed limit pair on wrong side of zero");
    a_torque_sign: assert property (p_torque_sign)
        else $error("direction flag disagrees with torque sign");
    a_frozen: assert property (p_frozen)
        else $error("torque moved during switchover");
    a_switch_bound: assert property (p_switch_bound)
        else $error("switchover outlasted its timer");
    c_pot_up: cover property (potUp && runCmd);
    c_pending: cover property (switchPending ##1 !switchPending);
    c_reverse: cover property (torqueReverse);
endmodule : stc_rc_assertions

bind stc_reference_conditioner stc_rc_assertions #(
    .NDI(NDI), .TICK_CYCLES(TICK_CYCLES)
) u_stc_rc_assertions (
    .clk(clk), .rst(rst), .digitalIn(digitalIn),
    .digitalInputFunction(digitalInputFunction), .runCmd(runCmd),
    .potRestore(potRestore), .controlMethodSelect(controlMethodSelect),
    .torqueRefDelay(torqueRefDelay), .modeSwitchTimer(modeSwitchTimer),
    .speedRef(speedRef), .motorPotReference(motorPotReference),
    .torqueMode(torqueMode), .switchPending(switchPending),
    .torqueRef(torqueRef), .torqueReverse(torqueReverse),
    .speedLimitHigh(speedLimitHigh), .speedLimitLow(speedLimitLow)
);

// file: testbench/stc_reference_conditioner_tb_top.sv
// self-checking bench for the reference conditioner
// assumes the checker file binds itself; ms tick shortened to 4 cycles
`timescale 1ns/1ps
module stc_reference_conditioner_tb_top;
    import stc_pkg::*;
    localparam int TK = 4;
    // contacts 0..5: pot up, pot down, trim up, trim down, mode, polarity
    localparam logic [47:0] FNS = 48'h78711d1c1110;
    logic clk = 1'b0, rst = 1'b1, runCmd = 1'b0, runRev = 1'b0;
    logic potSel = 1'b0, potMem = 1'b0, potRst = 1'b0, modeSel = 1'b0;
    logic uni2 = 1'b0, uni3 = 1'b0;
    logic [5:0] din = 6'h00;
    logic [15:0] skipC [3] = '{16'h0000, 16'h0000, 16'h0000};
    logic [15:0] width = 16'h0000, potVal = 16'h0000, anaRef = 16'h0000;
    logic [15:0] tDelay = 16'h0000, swTime = 16'h0000, e, p;
    logic [7:0] trim = 8'h00, fn2 = 8'h0d, fn3 = 8'h0e, bias = 8'h00;
    logic [3:0] method = 4'h3;
    logic [1:0] limSrc = 2'h2;
    logic signed [7:0] limVal = 8'sh00;
    stc_val_t term2 = 16'sh0000, term3 = 16'sh0000;
    logic [15:0] speedRef, motorPot, potSaved;
    logic torqueMode, pending, torqueRev;
    stc_val_t torqueRef, torqueComp, limHi, limLo;
    int fails = 0, n_compared = 0, v, x;

    always #4 clk = ~clk;

    stc_reference_conditioner #(.NDI(6), .TICK_CYCLES(TK)) u_stc_reference_conditioner (
        .clk(clk), .rst(rst), .digitalIn(din), .digitalInputFunction(FNS),
        .runCmd(runCmd), .runReverse(runRev), .skipCentreFirst(skipC[0]),
        .skipCentreSecond(skipC[1]), .skipCentreThird(skipC[2]),
        .skipBandWidth(width), .maxOutputFrequency(16'h0258),
        .potReferenceMemory(potMem), .potSelect(potSel),
        .accelStep(16'h0005), .decelStep(16'h0003), .potRestore(potRst),
        .potRestoreValue(potVal), .analogReference(anaRef),
        .trimStepLevel(trim), .analogTerminalTwo(term2),
        .analogTerminalThree(term3), .analogIn2Function(fn2),
        .analogIn3Function(fn3), .analogTwoUnipolar(uni2),
        .analogThreeUnipolar(uni3), .controlMethodSelect(method),
        .controlModeSelect(modeSel), .torqueRefDelay(tDelay),
        .speedLimitSource(limSrc), .speedLimitValue(limVal),
        .speedLimitBias(bias), .modeSwitchTimer(swTime),
        .speedRef(speedRef), .motorPotReference(motorPot),
        .potSavedRef(potSaved), .torqueMode(torqueMode),
        .switchPending(pending), .torqueRef(torqueRef),
        .torqueComp(torqueComp), .torqueReverse(torqueRev),
        .speedLimitHigh(limHi), .speedLimitLow(limLo)
    );

    // band side follows the previous output
    function automatic logic [15:0] skipF(input logic [15:0] c,
                                          input logic [15:0] prev);
        skipF = c;
        for (int i = 0; i < 3; i++) begin
            if (skipC[i] != 0 && c + width >= skipC[i] && c <= skipC[i] + width)
                skipF = (prev <= skipC[i]) ? skipC[i] - width : skipC[i] + width;
        end
    endfunction : skipF

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic chk(input string nm, input logic [15:0] ex,
                       input logic [15:0] got);
        n_compared++;
        if (got !== ex) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    initial begin
        #400000;
        fails++;
        test_done();
    end

    initial begin
        void'($urandom(32'h3bd3));
        step(4);
        rst = 1'b0;
        step(1);
        chk("reset ref", 16'h0000, speedRef);
        // random walk up and down through three bands, with edge corners
        skipC = '{16'h012c, 16'h01f4, 16'h02bc};
        width = 16'h000a;
        e = 16'h0000;
        x = 250;
        for (int i = 0; i < 160; i++) begin
            x = (i < 80) ? x + $urandom_range(0, 12) : x - $urandom_range(0, 12);
            if (i == 40) x = 510;
            if (i == 130) x = 490;
            anaRef = 16'(x);
            step(3);
            e = skipF(anaRef, e);
            chk("skip", e, speedRef);
        end
        // trim up, down, both, released
        skipC = '{16'h0000, 16'h0000, 16'h0000};
        anaRef = 16'h03e8;
        for (int k = 1; k <= 4; k++) begin
            trim = 8'($urandom_range(0, 100));
            din[3:2] = 2'(k);
            step(3);
            v = 1000 + ((k == 1) ? 6 : (k == 2) ? -6 : 0) * int'(trim);
            chk("trim", 16'(v), speedRef);
        end
        // pot ramps; tick phase leaves a one-step tolerance
        potSel = 1'b1;
        runCmd = 1'b1;
        din[0] = 1'b1;
        step(10 * TK);
        din[0] = 1'b0;
        step(3);
        p = motorPot;
        chk("pot up", 16'h0001, 16'(p >= 16'h0028 && p <= 16'h0037));
        din[1:0] = 2'h3;
        step(5 * TK);
        chk("pot both", p, motorPot);
        din[1:0] = 2'h2;
        step(4 * TK);
        din[1] = 1'b0;
        step(3);
        chk("pot down", 16'h0001, 16'(p - motorPot inside {[9:15]}));
        chk("pot select", motorPot, speedRef);
        p = motorPot;
        runCmd = 1'b0;
        step(3);
        chk("pot saved", p, potSaved);
        runCmd = 1'b1;
        step(3);
        chk("pot zero", 16'h0000, motorPot);
        din[0] = 1'b1;
        step(4 * TK);
        din[0] = 1'b0;
        potMem = 1'b1;
        step(3);
        p = motorPot;
        runCmd = 1'b0;
        step(3);
        runCmd = 1'b1;
        step(3);
        chk("pot memory", p, motorPot);
        potVal = 16'h007b;
        potRst = 1'b1;
        runCmd = 1'b0;
        step(1);
        potRst = 1'b0;
        step(3);
        chk("pot restore", 16'h007b, motorPot);
        // timed switchover with the torque input frozen meanwhile
        potSel = 1'b0;
        term2 = 16'sh00c8;
        swTime = 16'h0003;
        step(3);
        din[4] = 1'b1;
        step(2);
        term2 = 16'sh012c;
        step(2);
        chk("pending", 16'h0001, 16'(pending));
        chk("frozen", 16'h00c8, torqueRef);
        chk("mode wait", 16'h0000, 16'(torqueMode));
        step(4 * TK + 4);
        chk("mode on", 16'h0001, 16'(torqueMode));
        chk("thawed", 16'h012c, torqueRef);
        swTime = 16'h0000;
        din[4] = 1'b0;
        step(6);
        chk("mode off", 16'h0000, 16'(torqueMode));
        modeSel = 1'b1;
        step(4);
        chk("mode set", 16'h0001, 16'(torqueMode));
        method = 4'h2;
        step(4);
        chk("mode method", 16'h0000, 16'(torqueMode));
        // torque reference on either terminal, clamp and polarity
        for (int i = 0; i < 24; i++) begin
            v = $urandom_range(0, 2000) - 1000;
            {uni2, din[5]} = 2'($urandom_range(0, 3));
            uni3 = uni2;
            fn2 = i[0] ? 8'h0e : 8'h0d;
            fn3 = i[0] ? 8'h0d : 8'h0e;
            term2 = i[0] ? 16'sh0064 : 16'(v);
            term3 = i[0] ? 16'(v) : 16'sh0064;
            step(3);
            x = (uni2 && v < 0) ? 0 : v;
            if (din[5]) x = -x;
            chk("torque", 16'(x), torqueRef);
            chk("direction", 16'(x < 0), 16'(torqueRev));
            chk("comp", 16'h0064, torqueComp);
        end
        // first-order lag is slower than the step, then settles close
        fn2 = 8'h0d;
        fn3 = 8'h0e;
        din[5] = 1'b0;
        term2 = 16'sh0000;
        step(3);
        tDelay = 16'h0002;
        term2 = 16'sh0190;
        step(2);
        chk("delayed", 16'h0001, 16'(torqueRef != 16'sh0190));
        step(40 * TK);
        chk("settled", 16'h0001, 16'(torqueRef >= 16'sh018e));
        // speed limit source, sign and bias, 600 max gives 6 per percent
        for (int i = 0; i < 20; i++) begin
            limSrc = 2'($urandom_range(1, 2));
            limVal = 8'($urandom_range(0, 240) - 120);
            bias = 8'($urandom_range(0, 120));
            runRev = 1'($urandom_range(0, 1));
            step(4);
            x = (limSrc == 2'h2) ? 6 * int'(limVal) : 1000;
            if (runRev) x = -x;
            chk("limit high", 16'((x > 0 ? x : 0) + 6 * int'(bias)), limHi);
            chk("limit low", 16'((x < 0 ? x : 0) - 6 * int'(bias)), limLo);
        end
        test_done();
    end
endmodule : stc_reference_conditioner_tb_top
